// ==== rtl/serial_port_pkg.sv ====
// constants, field layouts and state types of the radio serial data port
// assumes nothing; imported by every design file of the port except rate_if
package serial_port_pkg;

   // ==========================================================
   // register byte offsets on the bus
   localparam logic [7:0] OFF_PIN_TWO_CONFIG  = 8'h00;
   localparam logic [7:0] OFF_PIN_ONE_CONFIG  = 8'h04;
   localparam logic [7:0] OFF_PIN_ZERO_CONFIG = 8'h08;
   localparam logic [7:0] OFF_PKT_CONTROL     = 8'h0C;
   localparam logic [7:0] OFF_MODEM_CONFIG    = 8'h10;
   localparam logic [7:0] OFF_RATE_DIV        = 8'h14;
   localparam logic [7:0] OFF_SYNC_WORD       = 8'h18;
   localparam logic [7:0] OFF_STATUS          = 8'h1C;

   // ==========================================================
   // field positions
   localparam int FMT_LSB        = 4;  // packet format, 2 bits
   localparam int WHITEN_BIT     = 6;
   localparam int FEC_BIT        = 3;
   localparam int MANCH_BIT      = 2;
   localparam int INTERLEAVE_BIT = 1;
   localparam int ADDR_BIT       = 0;
   localparam int MOD_LSB        = 4;  // modulation format, 3 bits
   localparam int SYNC_MODE_LSB  = 0;  // sync mode, 3 bits

   // ==========================================================
   // encodings
   localparam logic [1:0] FMT_NORMAL = 2'h0;
   localparam logic [1:0] FMT_SYNC   = 2'h1;
   localparam logic [1:0] FMT_ASYNC  = 2'h3;
   localparam logic [2:0] MOD_2FSK   = 3'h0;
   localparam logic [2:0] MOD_MSK    = 3'h7;
   localparam logic [5:0] SEL_SER_CLK    = 6'h0B;
   localparam logic [5:0] SEL_SYNC_DATA  = 6'h0C;
   localparam logic [5:0] SEL_ASYNC_DATA = 6'h0D;
   localparam logic [5:0] SEL_HIZ        = 6'h2E;

   // ==========================================================
   // reset values and counts
   localparam logic [5:0]  RST_PIN_SEL   = 6'h2E;
   localparam logic [7:0]  RST_PKT_CTRL  = 8'h00;
   localparam logic [7:0]  RST_MODEM_CFG = 8'h02;
   localparam logic [15:0] RST_RATE_DIV  = 16'h0010;
   localparam logic [15:0] RST_SYNC_WORD = 16'hD391;
   localparam logic [5:0]  PREAMBLE_BITS = 6'h20;
   localparam logic [5:0]  SYNC_BITS     = 6'h10;
   localparam logic [2:0]  PHASE_FALL    = 3'h0;
   localparam logic [2:0]  PHASE_RISE    = 3'h4;

   typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_DATA} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_DATA} rx_state_t;

endpackage

// ==== rtl/rate_if.sv ====
// carrier between the port core and its oversampling rate generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface rate_if #(parameter int DIV_W = 16);
   logic [DIV_W-1:0] div;   // clocks per oversample tick
   logic             run;   // generator enable
   logic             tick;  // one pulse per oversample tick
   logic [2:0]       phase; // eighth of the bit, valid with tick

   modport gen (input div, input run, output tick, output phase);
   modport use_side (output div, output run, input tick, input phase);
endinterface
`default_nettype wire

// ==== rtl/rate_gen.sv ====
// oversampling tick generator, eight ticks per bit period
// assumes div is at least one; clocked with the port core
`timescale 1ns/1ps
`default_nettype none
module rate_gen #(
   parameter int DIV_W = 16
) (
   input  wire logic CLK,
   input  wire logic RSTN,
   rate_if.gen       rt
);
   import serial_port_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic [2:0]       phase;
      logic             tick;
   } gen_state_t;

   gen_state_t s;
   gen_state_t next_s;

   if (DIV_W < 2) begin : g_bad_width
      $error("rate_gen: DIV_W must be at least 2");
   end

   // ==========================================================
   // divider and phase counter
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (!rt.run) begin
         next_s.cnt = '0;
         next_s.phase = 3'h7;
      end else if (s.cnt + 1'b1 >= rt.div) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
         next_s.phase = s.phase + 3'h1;
      end else begin
         next_s.cnt = s.cnt + 1'b1;
      end
   end

   // state register
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         s <= '{cnt: '0, phase: 3'h7, tick: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign rt.tick = s.tick;
   assign rt.phase = s.phase;
endmodule
`default_nettype wire

// ==== rtl/serial_data_port.sv ====
// serial data port of the radio: async and sync bit streaming over pins
// assumes an APB master on CLK; radio strobes and rx bit on CLK;
// the three general pins come from outside; only pin zero is synchronised here
`timescale 1ns/1ps
`default_nettype none
module serial_data_port #(
   parameter int DIV_W = 16
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        TX_ACTIVE,
   input  wire logic        RX_ACTIVE,
   input  wire logic        RX_BIT_IN,
   output logic             MOD_BIT,
   output logic [2:0]       MOD_FORMAT,
   output logic             PKT_HANDLER_ON,
   output logic [3:0]       CODING_ON,
   output logic             ADDR_FILTER_ON,
   input  wire logic [2:0]  PIN_I,
   output logic [2:0]       PIN_O,
   output logic [2:0]       PIN_OE
);
   import serial_port_pkg::*;

   typedef struct packed {
      logic [2:0][5:0]  pin_sel;
      logic [7:0]       pkt_ctrl;
      logic [7:0]       modem_cfg;
      logic [DIV_W-1:0] rate_div;
      logic [15:0]      sync_word;
      logic             sync_found;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      logic             pin0_meta;
      logic             pin0_sync;
      logic [2:0]       pin_out;
      logic [2:0]       pin_oe;
      tx_state_t        tx_state;
      logic [5:0]       tx_cnt;
      logic             mod_bit;
      logic             bit_clk;
      rx_state_t        rx_state;
      logic [15:0]      rx_shift;
      logic             rx_out;
      logic [2:0]       mod_fmt;
      logic             handler_on;
      logic [3:0]       coding_on;
      logic             addr_on;
   } port_state_t;

   port_state_t s;
   port_state_t next_s;

   if (DIV_W < 2 || DIV_W > 32) begin : g_bad_width
      $error("serial_data_port: DIV_W must be 2 to 32");
   end

   // ==========================================================
   // oversampling rate generator
   rate_if #(.DIV_W(DIV_W)) rt ();

   rate_gen #(
      .DIV_W (DIV_W)
   ) u_rate (
      .CLK  (CLK),
      .RSTN (RSTN),
      .rt   (rt.gen)
   );

   logic [1:0] fmt;
   logic [2:0] sync_mode;
   logic       is_async;
   logic       is_sync;
   logic       serial_on;
   logic       fall_tick;
   logic       rise_tick;

   // mode decode and bit timing strobes
   always_comb begin
      fmt       = s.pkt_ctrl[FMT_LSB +: 2];
      sync_mode = s.modem_cfg[SYNC_MODE_LSB +: 3];
      is_async  = (fmt == FMT_ASYNC);
      is_sync   = (fmt == FMT_SYNC);
      serial_on = is_async || is_sync;
      fall_tick = rt.tick && (rt.phase == PHASE_FALL);
      rise_tick = rt.tick && (rt.phase == PHASE_RISE);
   end

   assign rt.div = s.rate_div;
   // generator idles between transfers, so each starts with a falling tick
   assign rt.run = serial_on && (TX_ACTIVE || RX_ACTIVE);

   // ==========================================================
   // next state
   always_comb begin
      next_s = s;

      // bus slave, one wait cycle, write lands with pready
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      if (PSEL && PENABLE && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.prdata = 32'h0000_0000;
         case (PADDR)
            OFF_PIN_TWO_CONFIG: begin
               next_s.prdata[5:0] = s.pin_sel[2];
            end
            OFF_PIN_ONE_CONFIG: begin
               next_s.prdata[5:0] = s.pin_sel[1];
            end
            OFF_PIN_ZERO_CONFIG: begin
               next_s.prdata[5:0] = s.pin_sel[0];
            end
            OFF_PKT_CONTROL: begin
               next_s.prdata[7:0] = s.pkt_ctrl;
            end
            OFF_MODEM_CONFIG: begin
               next_s.prdata[7:0] = s.modem_cfg;
            end
            OFF_RATE_DIV: begin
               next_s.prdata[DIV_W-1:0] = s.rate_div;
            end
            OFF_SYNC_WORD: begin
               next_s.prdata[15:0] = s.sync_word;
            end
            OFF_STATUS: begin
               next_s.prdata[5:0] = {s.pin0_sync, s.sync_found,
                                     s.rx_state, s.tx_state};
            end
            default: begin
               next_s.pslverr = 1'b1;
            end
         endcase
      end
      if (PSEL && PENABLE && s.pready && PWRITE) begin
         case (PADDR)
            OFF_PIN_TWO_CONFIG: begin
               next_s.pin_sel[2] = PWDATA[5:0];
            end
            OFF_PIN_ONE_CONFIG: begin
               next_s.pin_sel[1] = PWDATA[5:0];
            end
            OFF_PIN_ZERO_CONFIG: begin
               next_s.pin_sel[0] = PWDATA[5:0];
            end
            OFF_PKT_CONTROL: begin
               next_s.pkt_ctrl = PWDATA[7:0];
            end
            OFF_MODEM_CONFIG: begin
               next_s.modem_cfg = PWDATA[7:0];
            end
            OFF_RATE_DIV: begin
               next_s.rate_div = PWDATA[DIV_W-1:0];
            end
            OFF_SYNC_WORD: begin
               next_s.sync_word = PWDATA[15:0];
            end
            OFF_STATUS: begin
               // write one clears the sync-found flag
               if (PWDATA[4]) begin
                  next_s.sync_found = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // pin zero synchroniser
      next_s.pin0_meta = PIN_I[0];
      next_s.pin0_sync = s.pin0_meta;

      // transmit sequencer
      case (s.tx_state)
         TX_IDLE: begin
            if (serial_on && TX_ACTIVE) begin
               next_s.tx_cnt = 6'h00;
               if (is_sync && sync_mode != 3'h0) begin
                  next_s.tx_state = TX_PRE;
               end else begin
                  next_s.tx_state = TX_DATA;
               end
            end
         end
         TX_PRE: begin
            // device sends 1010 preamble itself
            if (fall_tick) begin
               next_s.mod_bit = ~s.tx_cnt[0];
               next_s.tx_cnt = s.tx_cnt + 6'h01;
               if (s.tx_cnt == PREAMBLE_BITS - 6'h01) begin
                  next_s.tx_cnt = 6'h00;
                  next_s.tx_state = TX_SYNC;
               end
            end
         end
         TX_SYNC: begin
            if (fall_tick) begin
               next_s.mod_bit = s.sync_word[4'(SYNC_BITS - 6'h01
                                              - s.tx_cnt)];
               next_s.tx_cnt = s.tx_cnt + 6'h01;
               if (s.tx_cnt == SYNC_BITS - 6'h01) begin
                  next_s.tx_state = TX_DATA;
               end
            end
         end
         TX_DATA: begin
            if (is_async && rt.tick) begin
               next_s.mod_bit = s.pin0_sync;
            end else if (is_sync && rise_tick) begin
               next_s.mod_bit = s.pin0_sync;
            end
         end
         default: begin
            next_s.tx_state = TX_IDLE;
         end
      endcase
      if (!serial_on || !TX_ACTIVE) begin
         next_s.tx_state = TX_IDLE;
      end

      // receive sequencer
      case (s.rx_state)
         RX_IDLE: begin
            if (serial_on && RX_ACTIVE) begin
               if (is_sync && sync_mode != 3'h0) begin
                  next_s.rx_state = RX_HUNT;
               end else begin
                  next_s.rx_state = RX_DATA;
               end
            end
         end
         RX_HUNT: begin
            // payload only after the sync word is found
            if (fall_tick) begin
               next_s.rx_shift = {s.rx_shift[14:0], RX_BIT_IN};
               if ({s.rx_shift[14:0], RX_BIT_IN} == s.sync_word) begin
                  next_s.rx_state = RX_DATA;
                  next_s.sync_found = 1'b1;
               end
            end
         end
         RX_DATA: begin
            if (fall_tick) begin
               next_s.rx_out = RX_BIT_IN;
            end
         end
         default: begin
            next_s.rx_state = RX_IDLE;
         end
      endcase
      if (!serial_on || !RX_ACTIVE) begin
         next_s.rx_state = RX_IDLE;
      end

      // bit clock only for sync payload, never in async
      if (!(is_sync && (s.tx_state == TX_DATA
                        || s.rx_state == RX_DATA))) begin
         next_s.bit_clk = 1'b0;
      end else if (fall_tick) begin
         next_s.bit_clk = 1'b0;
      end else if (rise_tick) begin
         next_s.bit_clk = 1'b1;
      end

      // pin routing by signal select
      for (int i = 0; i < 3; i++) begin
         next_s.pin_oe[i] = 1'b1;
         case (s.pin_sel[i])
            SEL_SER_CLK: begin
               next_s.pin_out[i] = next_s.bit_clk;
            end
            SEL_SYNC_DATA: begin
               next_s.pin_out[i] = next_s.rx_out;
            end
            SEL_ASYNC_DATA: begin
               next_s.pin_out[i] = next_s.rx_out;
            end
            SEL_HIZ: begin
               next_s.pin_out[i] = 1'b0;
               next_s.pin_oe[i] = 1'b0;
            end
            default: begin
               next_s.pin_out[i] = 1'b0;
            end
         endcase
      end
      // pin zero becomes the transmit data input
      if (serial_on && TX_ACTIVE) begin
         next_s.pin_oe[0] = 1'b0;
      end

      // controls handed to the radio core
      next_s.mod_fmt = s.modem_cfg[MOD_LSB +: 3];
      if (is_async && s.modem_cfg[MOD_LSB +: 3] == MOD_MSK) begin
         next_s.mod_fmt = MOD_2FSK;
      end
      next_s.handler_on = !is_async;
      next_s.coding_on = {s.pkt_ctrl[WHITEN_BIT], s.pkt_ctrl[FEC_BIT],
                          s.pkt_ctrl[MANCH_BIT],
                          s.pkt_ctrl[INTERLEAVE_BIT]};
      if (is_async) begin
         next_s.coding_on = 4'h0;
      end
      next_s.addr_on = s.pkt_ctrl[ADDR_BIT] && !serial_on;
   end

   // ==========================================================
   // state register
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         s <= '0;
         s.pin_sel <= {RST_PIN_SEL, RST_PIN_SEL, RST_PIN_SEL};
         s.pkt_ctrl <= RST_PKT_CTRL;
         s.modem_cfg <= RST_MODEM_CFG;
         s.rate_div <= DIV_W'(RST_RATE_DIV);
         s.sync_word <= RST_SYNC_WORD;
         s.tx_state <= TX_IDLE;
         s.rx_state <= RX_IDLE;
         s.handler_on <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   assign PRDATA         = s.prdata;
   assign PREADY         = s.pready;
   assign PSLVERR        = s.pslverr;
   assign MOD_BIT        = s.mod_bit;
   assign MOD_FORMAT     = s.mod_fmt;
   assign PKT_HANDLER_ON = s.handler_on;
   assign CODING_ON      = s.coding_on;
   assign ADDR_FILTER_ON = s.addr_on;
   assign PIN_O          = s.pin_out;
   assign PIN_OE         = s.pin_oe;
endmodule
`default_nettype wire

// ==== tb/serial_port_properties.sv ====
// assertions on the top ports of the radio serial data port
// assumes the design package is compiled first; bound at the file foot
`timescale 1ns/1ps
`default_nettype none
module serial_port_properties #(
   parameter int DIV_W = 16
) (
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        TX_ACTIVE,
   input wire logic [2:0]  MOD_FORMAT,
   input wire logic        PKT_HANDLER_ON,
   input wire logic [3:0]  CODING_ON,
   input wire logic        ADDR_FILTER_ON,
   input wire logic [2:0]  PIN_OE
);
   import serial_port_pkg::*;
   logic [1:0] fmt;
   logic [2:0] mdf;
   logic [1:0] settle;
   logic       wr_done;
   logic       cfg_wr;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   // ==========================================================
   // mode as software set it; settle counts cycles since a mode register write, up to three
   assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
   assign cfg_wr = wr_done && (PADDR == OFF_PKT_CONTROL
                               || PADDR == OFF_MODEM_CONFIG);
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         fmt    <= RST_PKT_CTRL[FMT_LSB +: 2];
         mdf    <= RST_MODEM_CFG[MOD_LSB +: 3];
         settle <= 2'h0;
      end else begin
         if (wr_done && PADDR == OFF_PKT_CONTROL)
            fmt <= PWDATA[FMT_LSB +: 2];
         if (wr_done && PADDR == OFF_MODEM_CONFIG)
            mdf <= PWDATA[MOD_LSB +: 3];
         if (cfg_wr)
            settle <= 2'h0;
         else if (settle != 2'h3)
            settle <= settle + 2'h1;
      end
   end

   // ==========================================================
   // bus handshake
   sequence setup_s;
      PSEL && !PENABLE;
   endsequence
   sequence access_s;
      PSEL && PENABLE && !PREADY;
   endsequence
   chk_ready_wait: assert property (setup_s ##1 access_s |=> PREADY)
      else $error("ready missing in second access cycle");
   chk_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held beyond one cycle");
   chk_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error flag without ready");
   chk_err_decode: assert property (PREADY && PADDR[1:0] == 2'h0
      |-> PSLVERR == (PADDR > OFF_STATUS))
      else $error("error flag does not match address");

   // ==========================================================
   // mode effects
   chk_async_bypass: assert property (
      settle == 2'h3 && fmt == FMT_ASYNC
      |-> !PKT_HANDLER_ON && CODING_ON == 4'h0)
      else $error("packet features on in async mode");
   chk_no_msk: assert property (
      settle == 2'h3 && fmt == FMT_ASYNC && mdf == MOD_MSK
      |-> MOD_FORMAT == MOD_2FSK)
      else $error("msk kept in async mode");
   chk_addr_sync: assert property (
      settle == 2'h3 && fmt == FMT_SYNC |-> !ADDR_FILTER_ON)
      else $error("address filter on in sync mode");
   chk_pin0_input: assert property (
      settle == 2'h3 && fmt[0] && TX_ACTIVE && $past(TX_ACTIVE)
      |-> !PIN_OE[0])
      else $error("pin zero driven during serial transmit");
endmodule

bind serial_data_port serial_port_properties #(.DIV_W(DIV_W)) u_props (
   .CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
   .PSLVERR, .TX_ACTIVE, .MOD_FORMAT, .PKT_HANDLER_ON, .CODING_ON,
   .ADDR_FILTER_ON, .PIN_OE
);
`default_nettype wire

// ==== tb/host_mcu_model.sv ====
// host controller model at the far side of the general pins
// assumes the bench resolves pin levels; lclk is the host's own clock
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
   input  wire logic        lclk,
   input  wire logic        en,
   input  wire logic        sync_mode,
   input  wire logic        bit_clk,
   input  wire logic        rx_pin,
   input  wire logic [15:0] word,
   output logic             drv,
   output logic             oe,
   output logic [15:0]      rx_word
);
   logic [3:0] ai = 4'h0;
   logic [3:0] si = 4'h0;

   // ==========================================================
   // async: one bit per own clock, period equal to the bit time
   always @(posedge lclk) ai <= en ? ai + 4'h1 : 4'h0;
   // sync: next bit once the device clock falls
   always @(negedge bit_clk or negedge en)
      if (!en)
         si <= 4'h0;
      else
         si <= si + 4'h1;
   // sync receive: sample on the rising device clock
   always @(posedge bit_clk) rx_word <= {rx_word[14:0], rx_pin};
   // raw bits, msb first; host frames the stream itself
   assign oe = en;
   assign drv = word[4'hF - (sync_mode ? si : ai)];
endmodule
`default_nettype wire

// ==== tb/radio_serial_data_port_tb.sv ====
// self-checking bench of the radio serial data port
// assumes design package, design, checker and host model compiled first
`timescale 1ns/1ps
`default_nettype none
module radio_serial_data_port_tb;
   import serial_port_pkg::*;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] r;
      logic        e;
      logic [8:0]  o;
   } row_t;
   logic        CLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
   logic        PWRITE = 1'b0, TX_ACTIVE = 1'b0, RX_ACTIVE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic        PREADY, PSLVERR, er, RX_BIT_IN = 1'b0, MOD_BIT;
   logic        PKT_HANDLER_ON, ADDR_FILTER_ON, h_drv, h_oe;
   logic [2:0]  MOD_FORMAT, PIN_O, PIN_OE, pin;
   logic [3:0]  CODING_ON;
   logic        lclk = 1'b0, tog = 1'b0, clk_q = 1'b0, h_en = 1'b0;
   logic        h_sync = 1'b0, rx_follow = 1'b0, rx_lvl = 1'b0;
   logic [15:0] word = 16'hB4E1, mod_sr = 16'h0, h_rx;
   int          errors = 0, n_checks = 0, rises = 0, falls = 0;
   int          r0 = 0, cycles = 0;
   row_t        rows [10] = '{
      '{8'h00, 32'h000000FF, 32'h3F, 1'b0, 9'h100},
      '{8'h04, 32'h0000000B, 32'h0B, 1'b0, 9'h100},
      '{8'h08, 32'h0000000D, 32'h0D, 1'b0, 9'h100},
      '{8'h14, 32'h00000001, 32'h01, 1'b0, 9'h100},
      '{8'h18, 32'hFFFFA5C3, 32'hA5C3, 1'b0, 9'h100},
      '{8'h10, 32'h00000070, 32'h70, 1'b0, 9'h107},
      '{8'h0C, 32'h0000004D, 32'h4D, 1'b0, 9'h1EF},
      '{8'h0C, 32'h0000005D, 32'h5D, 1'b0, 9'h1E7},
      '{8'h0C, 32'h0000007D, 32'h7D, 1'b0, 9'h000},
      '{8'h20, 32'h00001234, 32'h00, 1'b1, 9'h000}};
   logic [31:0] rv [7] = '{32'(RST_PIN_SEL), 32'(RST_PIN_SEL),
      32'(RST_PIN_SEL), 32'(RST_PKT_CTRL), 32'(RST_MODEM_CFG),
      32'(RST_RATE_DIV), 32'(RST_SYNC_WORD)};

   // ==========================================================
   // clocks; host clock has its own phase
   always #2 CLK = ~CLK;
   initial begin
      #1.3;
      forever #16 lclk = ~lclk;
   end

   // pins: device, then host on pin zero only, else a level that keeps changing
   assign pin[0] = PIN_OE[0] ? PIN_O[0] : (h_oe ? h_drv : tog);
   assign pin[1] = PIN_OE[1] ? PIN_O[1] : tog;
   assign pin[2] = PIN_OE[2] ? PIN_O[2] : tog;

   serial_data_port DUT (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR,
      .PWDATA, .PRDATA, .PREADY, .PSLVERR, .TX_ACTIVE, .RX_ACTIVE,
      .RX_BIT_IN, .MOD_BIT, .MOD_FORMAT, .PKT_HANDLER_ON, .CODING_ON,
      .ADDR_FILTER_ON, .PIN_I(pin), .PIN_O, .PIN_OE);

   host_mcu_model host (.lclk, .en(h_en), .sync_mode(h_sync),
      .bit_clk(pin[1]), .rx_pin(pin[2]), .word, .drv(h_drv), .oe(h_oe),
      .rx_word(h_rx));

   // bit clock edges, tx bit capture, rx bit source, timeout
   always @(posedge CLK) begin
      tog <= ~tog;
      clk_q <= pin[1];
      cycles <= cycles + 1;
      if (pin[1] && !clk_q)
         rises <= rises + 1;
      if (!pin[1] && clk_q) begin
         falls <= falls + 1;
         mod_sr <= {mod_sr[14:0], MOD_BIT};
      end
      RX_BIT_IN <= rx_follow ? word[4'hF - 4'(rises - r0)] : rx_lvl;
      if (cycles == 6000) begin
         errors = errors + 1;
         end_of_test();
      end
   end

   // ==========================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic [31:0] d,
                      input logic w, output logic [31:0] r,
                      output logic e);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PADDR <= a;
      PWDATA <= d;
      PWRITE <= w;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      // idle cycle, so a following call never reassigns in this step
      @(posedge CLK);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, d, 1'b1, rd, er);
   endtask

   // sixteen sync bits each way, counted on the device clock
   task automatic stream(input logic tx);
      int f0 = falls;
      r0 = rises;
      if (tx)
         TX_ACTIVE <= 1'b1;
      else
         RX_ACTIVE <= 1'b1;
      while ((tx ? falls - f0 : rises - r0) < 16)
         @(posedge CLK);
      if (tx)
         check(32'(mod_sr), 32'(word), "sync tx word");
      else
         check(32'(h_rx), 32'(word), "sync rx word");
      TX_ACTIVE <= 1'b0;
      RX_ACTIVE <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic end_of_test;
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   initial begin
      repeat (16) @(posedge CLK);
      RSTN <= 1'b1;
      @(posedge CLK);
      // register rows with the mode outputs they set
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         check(32'(er), 32'(rows[i].e), "write error");
         apb(rows[i].a, 32'h0, 1'b0, rd, er);
         check(rd, rows[i].r, "read data");
         check(32'(er), 32'(rows[i].e), "read error");
         check(32'({PKT_HANDLER_ON, CODING_ON, ADDR_FILTER_ON,
            MOD_FORMAT}), 32'(rows[i].o), "mode outputs");
      end
      // async transmit from pin zero
      wr(OFF_PIN_ONE_CONFIG, 32'(SEL_SER_CLK));
      wr(OFF_PIN_TWO_CONFIG, 32'(SEL_ASYNC_DATA));
      wr(OFF_PKT_CONTROL, 32'h30);
      r0 = rises;
      h_en <= 1'b1;
      TX_ACTIVE <= 1'b1;
      repeat (12) begin
         @(posedge lclk);
         repeat (5) @(posedge CLK);
         check(32'(MOD_BIT), 32'(pin[0]), "async tx bit");
      end
      TX_ACTIVE <= 1'b0;
      h_en <= 1'b0;
      // async receive as a level stream, no clock
      RX_ACTIVE <= 1'b1;
      rx_lvl <= 1'b1;
      repeat (24) @(posedge CLK);
      check(32'({PIN_OE[2], PIN_O[2]}), 32'h3, "async rx high");
      rx_lvl <= 1'b0;
      repeat (24) @(posedge CLK);
      check(32'({PIN_OE[2], PIN_O[2]}), 32'h2, "async rx low");
      check(32'(rises - r0), 32'h0, "async bit clock");
      RX_ACTIVE <= 1'b0;
      // sync mode, framing left to the host
      wr(OFF_RATE_DIV, 32'h2);
      wr(OFF_PIN_TWO_CONFIG, 32'(SEL_SYNC_DATA));
      wr(OFF_MODEM_CONFIG, 32'h00);
      wr(OFF_PKT_CONTROL, 32'h10);
      h_sync <= 1'b1;
      h_en <= 1'b1;
      stream(1'b1);
      h_en <= 1'b0;
      rx_follow <= 1'b1;
      stream(1'b0);
      rx_follow <= 1'b0;
      // sync mode with preamble and sync word by the device
      wr(OFF_MODEM_CONFIG, 32'h01);
      r0 = rises;
      TX_ACTIVE <= 1'b1;
      repeat (700) @(posedge CLK);
      check(32'(rises - r0), 32'h0, "clock in preamble");
      repeat (300) @(posedge CLK);
      check(32'(rises - r0 > 0), 32'h1, "payload clock");
      TX_ACTIVE <= 1'b0;
      // receive hunt: an all-ones stream matches an all-ones sync word
      wr(OFF_SYNC_WORD, 32'hFFFF);
      rx_lvl <= 1'b1;
      RX_ACTIVE <= 1'b1;
      repeat (400) @(posedge CLK);
      apb(OFF_STATUS, 32'h0, 1'b0, rd, er);
      check(rd & 32'h1C, 32'h18, "sync found");
      RX_ACTIVE <= 1'b0;
      // second reset in mid-run
      RSTN <= 1'b0;
      repeat (16) @(posedge CLK);
      check(32'({PREADY, PSLVERR, MOD_BIT, PKT_HANDLER_ON, CODING_ON,
         ADDR_FILTER_ON, PIN_OE}), 32'h100, "reset outputs");
      RSTN <= 1'b1;
      @(posedge CLK);
      foreach (rv[i]) begin
         apb(8'(i * 4), 32'h0, 1'b0, rd, er);
         check(rd, rv[i], "reset value");
      end
      end_of_test();
   end
endmodule
`default_nettype wire
